/* pim_pkg.sv */
// constants and carrier types of the phy interrupt manager
package pim_pkg;
	// ============================================================
	// register offsets on the management port
	localparam logic [4:0] REG_BASIC_STATUS = 5'h01; // basic status, read clears some flags
	localparam logic [4:0] REG_AN_EXPANSION = 5'h06; // expansion, read clears fault/page
	localparam logic [4:0] REG_MODE_CTRL    = 5'h11; // mode control, holds the alt select
	localparam logic [4:0] REG_IRQ_FLAGS    = 5'h1D; // interrupt source flags
	localparam logic [4:0] REG_IRQ_MASK     = 5'h1E; // interrupt mask

	// ============================================================
	// field positions
	localparam int ALT_SEL_BIT   = 6; // alt release scheme select in mode control
	localparam int SRC_ENERGY    = 7; // line energy detect
	localparam int SRC_AN_DONE   = 6; // negotiation complete
	localparam int SRC_REM_FAULT = 5; // remote fault
	localparam int SRC_LINK_DOWN = 4; // link down (inverted link status)
	localparam int SRC_LP_ACK    = 3; // partner acknowledge
	localparam int SRC_PD_FAULT  = 2; // parallel detection fault
	localparam int SRC_PAGE_RX   = 1; // page received

	// ============================================================
	// reset values
	localparam logic [7:1] FLAGS_RST = 7'h00; // flags start clear
	localparam logic [7:1] MASK_RST  = 7'h00; // every source masked
	localparam logic       ALT_RST   = 1'b0;  // primary scheme after reset

	// ============================================================
	// timing of the late energy pulse
	localparam int CLK_KHZ         = 20000; // 20 MHz core clock
	localparam int ENERGY_DELAY_MS = 1000;  // wait after energy drops
	localparam int ENERGY_PULSE_MS = 256;   // length of the late pulse
	localparam int ENERGY_DELAY_CYC = ENERGY_DELAY_MS * CLK_KHZ;
	localparam int ENERGY_PULSE_CYC = ENERGY_PULSE_MS * CLK_KHZ;

	// ============================================================
	// carrier types
	typedef struct packed {
		logic line_energy_detect; // energy status
		logic an_complete;        // negotiation complete status
		logic remote_fault;       // remote fault status
		logic link_status;        // link up status
		logic lp_acknowledge;     // partner acknowledge status
		logic pd_fault;           // parallel detection fault status
		logic page_received;      // page received status
	} pim_status_s;

	typedef struct packed {
		logic [4:0]  addr;  // register index
		logic        rd;    // read strobe, one cycle
		logic        wr;    // write strobe, one cycle
		logic [15:0] wdata; // write data
	} pim_reg_req_s;
endpackage

/* pim_src_edge.sv */
// edge detector for the seven interrupt sources
`timescale 1ns/1ps
module pim_src_edge (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// sources, link already inverted
	input  wire logic [7:1] src_in,
	// edges
	output logic      [7:1] rise_out,
	output logic      [7:1] fall_out
);
	// ============================================================
	// state
	typedef struct packed {
		logic [7:1] prev; // sources one cycle ago
	} pim_edge_s;

	pim_edge_s s_reg;  // registered state
	pim_edge_s s_next; // next state

	// prev resets low so a source already high at release counts as a rise
	always_comb begin
		s_next      = s_reg;
		s_next.prev = src_in;
	end

	// register the copy
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s_reg.prev <= 7'h00; // [R20]
		end else begin
			s_reg <= s_next;
		end
	end

	assign rise_out = src_in & ~s_reg.prev;
	assign fall_out = ~src_in & s_reg.prev;
endmodule

/* pim_energy_timer.sv */
// delayed energy pulse after cable removal
`timescale 1ns/1ps
module pim_energy_timer #(
	parameter int unsigned DELAY_CYC = pim_pkg::ENERGY_DELAY_CYC,
	parameter int unsigned PULSE_CYC = pim_pkg::ENERGY_PULSE_CYC
) (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_in,
	// control
	input  wire logic arm_in,    // flag released while energy present
	input  wire logic enable_in, // energy mask bit
	input  wire logic energy_in, // energy status
	// result
	output logic      pulse_out  // late interrupt request
);
	// ============================================================
	// states
	typedef enum logic [3:0] {
		T_IDLE  = 4'b0001,
		T_ARMED = 4'b0010,
		T_WAIT  = 4'b0100,
		T_PULSE = 4'b1000
	} pim_tmr_e;

	typedef struct packed {
		pim_tmr_e    st;  // phase
		logic [24:0] cnt; // cycle counter
	} pim_tmr_s;

	pim_tmr_s s_reg;  // registered state
	pim_tmr_s s_next; // next state

	// a masked source aborts the sequence at any phase
	always_comb begin
		s_next = s_reg;
		unique case (s_reg.st)
			T_IDLE: begin
				if (arm_in && enable_in) begin
					s_next.st = T_ARMED;
				end
			end
			T_ARMED: begin
				if (!enable_in) begin
					s_next.st = T_IDLE;
				end else if (!energy_in) begin
					s_next.st  = T_WAIT;
					s_next.cnt = 25'h0000000;
				end
			end
			T_WAIT: begin
				if (!enable_in) begin
					s_next.st = T_IDLE;
				end else if (energy_in) begin
					s_next.st = T_ARMED;
				end else if (s_reg.cnt == 25'(DELAY_CYC - 1)) begin
					s_next.st  = T_PULSE;
					s_next.cnt = 25'h0000000;
				end else begin
					s_next.cnt = s_reg.cnt + 25'h0000001;
				end
			end
			T_PULSE: begin
				if (!enable_in || s_reg.cnt == 25'(PULSE_CYC - 1)) begin
					s_next.st = T_IDLE;
				end else begin
					s_next.cnt = s_reg.cnt + 25'h0000001;
				end
			end
			default: s_next.st = T_IDLE;
		endcase
	end

	// register the copy
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s_reg.st  <= T_IDLE;
			s_reg.cnt <= 25'h0000000;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pulse_out = (s_reg.st == T_PULSE);

	// ============================================================
	// checks
	pulse_holds_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R18]
		$rose(pulse_out) && enable_in |=> pulse_out || !enable_in || PULSE_CYC == 1)
		else $error("late energy pulse ended at once");
	cov_late_pulse: cover property (@(posedge clk_in) disable iff (rst_in) $rose(pulse_out));
endmodule

/* pim_irq_manager.sv */
// interrupt flag, mask and release logic of the phy
`timescale 1ns/1ps

// Functional notes
// R1: interrupt output active low, unclocked at the pin; the code drives the pin from a flip-flop
// R2: primary release scheme after every reset
// R3: writing one to mode bit selects alternate
// R4: host reprograms alternate scheme after reset
// R5: each mask bit gates its matching flag
// R6: rising status sets flag; link uses falling
// R7: primary mode releases on the source's event
// R8: energy flag clears on fall or flag read
// R9: negotiation flag clears on fall or read
// R10: remote fault clears on fall, status reads
// R11: link down clears only on status reads
// R12: acknowledge flag clears on fall or read
// R13: detection fault has five release events
// R14: page received has five release events
// R15: alternate: clearing mask releases output at once
// R16: alternate: writing one re-examines the source
// R17: clear only when source is back idle
// R18: late 256 ms energy pulse after removal
// R19: host should mask energy inside its handler
// R20: energy flag reads one at power up
// R21: flags read only and latch high
// R22: output is or of masked flags, inverted
module pim_irq_manager #(
	parameter int unsigned ENERGY_DELAY_CYC = pim_pkg::ENERGY_DELAY_CYC,
	parameter int unsigned ENERGY_PULSE_CYC = pim_pkg::ENERGY_PULSE_CYC
) (
	// clock and reset
	input  wire logic                  MCLK_IN,
	input  wire logic                  RST_IN,
	// internal status sources
	input  wire pim_pkg::pim_status_s  STATUS_IN,
	input  wire logic                  AN_RESTART_IN,
	// management register port
	input  wire pim_pkg::pim_reg_req_s REG_REQ_IN,
	output logic [15:0]                REG_RDATA_OUT,
	output logic                       REG_RVALID_OUT,
	// interrupt and mode
	output logic                       IRQ_N_OUT,
	output logic                       ALT_IRQ_SELECT_OUT
);
	// ============================================================
	// helpers

	// one address decode used for every register strobe
	function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] off,
		input logic strobe);
		reg_hit = strobe && (addr == off);
	endfunction

	// ============================================================
	// state
	typedef struct packed {
		logic [7:1]  flags;          // latched source flags
		logic [7:1]  mask;           // source enables
		logic        alt_irq_select; // alternate release scheme
		logic        irq_out_n;      // registered interrupt level
		logic [15:0] rdata;          // read data
		logic        rvalid;         // read answer valid
	} pim_state_s;

	pim_state_s s_reg;  // registered state
	pim_state_s s_next; // next state

	logic [7:1] src_eff;     // sources, link inverted so every set is a rise
	logic [7:1] src_rise;    // set events
	logic [7:1] src_fall;    // source returned idle
	logic       late_pulse;  // delayed energy request
	logic       energy_arm;  // energy flag released while energy still high
	logic [7:1] clr_primary; // primary scheme release events
	logic [7:1] clr_alt;     // alternate scheme checked clears
	logic [7:1] clr_any;     // release for the active scheme
	logic       rd_flags;    // read of the flag register
	logic       rd_basic;    // read of the basic status register
	logic       rd_expan;    // read of the expansion register
	logic       wr_flags;    // write of the flag register
	logic       wr_mask;     // write of the mask register
	logic       wr_mode;     // write of the mode control register

	// ============================================================
	// source conditioning

	// link down is the only falling-edge source; invert it once here
	always_comb begin
		src_eff                        = 7'h00;
		src_eff[pim_pkg::SRC_ENERGY]    = STATUS_IN.line_energy_detect;
		src_eff[pim_pkg::SRC_AN_DONE]   = STATUS_IN.an_complete;
		src_eff[pim_pkg::SRC_REM_FAULT] = STATUS_IN.remote_fault;
		src_eff[pim_pkg::SRC_LINK_DOWN] = ~STATUS_IN.link_status;
		src_eff[pim_pkg::SRC_LP_ACK]    = STATUS_IN.lp_acknowledge;
		src_eff[pim_pkg::SRC_PD_FAULT]  = STATUS_IN.pd_fault;
		src_eff[pim_pkg::SRC_PAGE_RX]   = STATUS_IN.page_received;
	end

	// edge detection of all sources
	pim_src_edge u_edge (
		.clk_in   (MCLK_IN),
		.rst_in   (RST_IN),
		.src_in   (src_eff),
		.rise_out (src_rise),
		.fall_out (src_fall)
	);

	// late pulse after the cable goes away
	pim_energy_timer #(
		.DELAY_CYC (ENERGY_DELAY_CYC),
		.PULSE_CYC (ENERGY_PULSE_CYC)
	) u_energy (
		.clk_in    (MCLK_IN),
		.rst_in    (RST_IN),
		.arm_in    (energy_arm),
		.enable_in (s_reg.mask[pim_pkg::SRC_ENERGY]),
		.energy_in (STATUS_IN.line_energy_detect),
		.pulse_out (late_pulse)
	);

	// ============================================================
	// register strobes
	assign rd_flags = reg_hit(REG_REQ_IN.addr, pim_pkg::REG_IRQ_FLAGS, REG_REQ_IN.rd);
	assign rd_basic = reg_hit(REG_REQ_IN.addr, pim_pkg::REG_BASIC_STATUS, REG_REQ_IN.rd);
	assign rd_expan = reg_hit(REG_REQ_IN.addr, pim_pkg::REG_AN_EXPANSION, REG_REQ_IN.rd);
	assign wr_flags = reg_hit(REG_REQ_IN.addr, pim_pkg::REG_IRQ_FLAGS, REG_REQ_IN.wr);
	assign wr_mask  = reg_hit(REG_REQ_IN.addr, pim_pkg::REG_IRQ_MASK, REG_REQ_IN.wr);
	assign wr_mode  = reg_hit(REG_REQ_IN.addr, pim_pkg::REG_MODE_CTRL, REG_REQ_IN.wr);

	// ============================================================
	// release events

	// primary scheme: each source has its own set of release events
	always_comb begin
		clr_primary = 7'h00;
		// a fall of the source releases all but link down [R7]
		clr_primary[pim_pkg::SRC_ENERGY]    = src_fall[pim_pkg::SRC_ENERGY];    // [R8]
		clr_primary[pim_pkg::SRC_AN_DONE]   = src_fall[pim_pkg::SRC_AN_DONE];   // [R9]
		clr_primary[pim_pkg::SRC_REM_FAULT] = src_fall[pim_pkg::SRC_REM_FAULT] | rd_basic; // [R10]
		// a returning link leaves the link flag alone
		clr_primary[pim_pkg::SRC_LINK_DOWN] = rd_basic; // [R11]
		clr_primary[pim_pkg::SRC_LP_ACK]    = src_fall[pim_pkg::SRC_LP_ACK];    // [R12]
		// detection fault and page: expansion read, restart or link loss too
		clr_primary[pim_pkg::SRC_PD_FAULT]  = src_fall[pim_pkg::SRC_PD_FAULT] | rd_expan
			| AN_RESTART_IN | src_rise[pim_pkg::SRC_LINK_DOWN]; // [R13]
		clr_primary[pim_pkg::SRC_PAGE_RX]   = src_fall[pim_pkg::SRC_PAGE_RX] | rd_expan
			| AN_RESTART_IN | src_rise[pim_pkg::SRC_LINK_DOWN]; // [R14]
		// any read of the flag register releases every flag
		if (rd_flags) begin
			clr_primary = 7'h7F; // [R8] [R9] [R10] [R11] [R12]
		end
	end

	// alternate scheme: a one written only clears where the source is idle
	always_comb begin
		clr_alt = 7'h00;
		if (wr_flags) begin
			clr_alt = REG_REQ_IN.wdata[7:1] & ~src_eff; // [R16] [R17]
		end
	end

	assign clr_any = s_reg.alt_irq_select ? clr_alt : clr_primary;
	// primary release events have no effect in the alternate scheme

	// ============================================================
	// next state
	always_comb begin
		s_next = s_reg;
		// flags latch high; a new event in the clearing cycle wins [R21]
		s_next.flags = src_rise | (s_reg.flags & ~clr_any); // [R6]
		// mask is plain read/write; bit 0 and the upper byte stay zero
		if (wr_mask) begin
			s_next.mask = REG_REQ_IN.wdata[7:1]; // [R5] [R15]
		end
		// mode bit write selects the release scheme
		if (wr_mode) begin
			s_next.alt_irq_select = REG_REQ_IN.wdata[pim_pkg::ALT_SEL_BIT]; // [R3]
		end
		// read answers; the value is the one before this cycle's clear
		s_next.rvalid = 1'b0;
		s_next.rdata  = 16'h0000;
		if (rd_flags) begin
			s_next.rvalid = 1'b1;
			s_next.rdata  = {8'h00, s_reg.flags, 1'b0}; // [R21]
		end else if (reg_hit(REG_REQ_IN.addr, pim_pkg::REG_IRQ_MASK, REG_REQ_IN.rd)) begin
			s_next.rvalid = 1'b1;
			s_next.rdata  = {8'h00, s_reg.mask, 1'b0};
		end
		// output follows masked flags with no event memory of its own;
		// the late energy pulse rides the same mask bit
		s_next.irq_out_n = ~(|(s_next.flags & s_next.mask)
			| (late_pulse & s_next.mask[pim_pkg::SRC_ENERGY])); // [R22] [R1] [R18]
	end

	// arm the late pulse when a read drops the energy flag under live energy
	// an alternate check cannot arm it, as it needs energy low
	assign energy_arm = s_reg.flags[pim_pkg::SRC_ENERGY] & ~s_next.flags[pim_pkg::SRC_ENERGY]
		& STATUS_IN.line_energy_detect; // [R18]

	// ============================================================
	// state register

	// reset always returns to the primary scheme; the alternate one is lost
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			s_reg.flags          <= pim_pkg::FLAGS_RST;
			s_reg.mask           <= pim_pkg::MASK_RST;
			s_reg.alt_irq_select <= pim_pkg::ALT_RST; // [R2]
			s_reg.irq_out_n      <= 1'b1;
			s_reg.rdata          <= 16'h0000;
			s_reg.rvalid         <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ============================================================
	// outputs, all from flip-flops; the pin is registered, one cycle late
	// registering the pin trades one cycle for a glitch-free line
	assign IRQ_N_OUT          = s_reg.irq_out_n; // [R1]
	assign ALT_IRQ_SELECT_OUT = s_reg.alt_irq_select;
	assign REG_RDATA_OUT      = s_reg.rdata;
	assign REG_RVALID_OUT     = s_reg.rvalid;

	// ============================================================
	// checks
	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (RST_IN);
	// checks look one edge on, as the pin is registered; a fresh
	// rise in a release cycle keeps its flag, so most exclude it

	// energy high at release shows as a set flag one cycle on
	energy_boot_a: assert property ( // [R20]
		$fell(RST_IN) && STATUS_IN.line_energy_detect |=> s_reg.flags[pim_pkg::SRC_ENERGY])
		else $error("energy flag not set after reset");

	primary_reset_a: assert property ( // [R2]
		$fell(RST_IN) |-> !ALT_IRQ_SELECT_OUT)
		else $error("alternate scheme survived reset");

	alt_select_a: assert property ( // [R3]
		wr_mode && REG_REQ_IN.wdata[pim_pkg::ALT_SEL_BIT] |=> ALT_IRQ_SELECT_OUT)
		else $error("mode write did not select alternate scheme");

	masked_quiet_a: assert property ( // [R5]
		s_reg.mask == 7'h00 && !wr_mask |=> IRQ_N_OUT)
		else $error("interrupt driven with all sources masked");

	pending_low_a: assert property ( // [R22]
		|(s_reg.flags & s_reg.mask) |-> !IRQ_N_OUT)
		else $error("pending masked flag not on the output");

	rise_sets_a: assert property ( // [R6]
		|src_rise |=> (s_reg.flags & $past(src_rise)) == $past(src_rise))
		else $error("source edge did not set its flag");

	read_clears_a: assert property ( // [R8]
		!s_reg.alt_irq_select && rd_flags && src_rise == 7'h00 |=> s_reg.flags == 7'h00)
		else $error("flag read left a flag set in primary mode");

	link_hold_a: assert property ( // [R11]
		!s_reg.alt_irq_select && s_reg.flags[pim_pkg::SRC_LINK_DOWN] && !rd_flags
		&& !rd_basic |=> s_reg.flags[pim_pkg::SRC_LINK_DOWN])
		else $error("link down flag cleared without a read");

	restart_clr_a: assert property ( // [R13]
		!s_reg.alt_irq_select && AN_RESTART_IN && !src_rise[pim_pkg::SRC_PD_FAULT]
		|=> !s_reg.flags[pim_pkg::SRC_PD_FAULT])
		else $error("restart did not release detection fault");

	alt_keep_a: assert property ( // [R17]
		s_reg.alt_irq_select |=> ($past(s_reg.flags & src_eff) & ~s_reg.flags) == 7'h00)
		else $error("alternate mode dropped a flag whose source is active");

	alt_check_a: assert property ( // [R16]
		s_reg.alt_irq_select && wr_flags && src_rise == 7'h00
		|=> (s_reg.flags & $past(REG_REQ_IN.wdata[7:1] & ~src_eff)) == 7'h00)
		else $error("checked flag with idle source not cleared");

	mask_release_a: assert property ( // [R15]
		wr_mask && REG_REQ_IN.wdata[7:1] == 7'h00 |=> IRQ_N_OUT)
		else $error("clearing the mask did not release the output");

	// a status read releases remote fault
	remote_read_a: assert property ( // [R10]
		!s_reg.alt_irq_select && rd_basic && !src_rise[pim_pkg::SRC_REM_FAULT]
		|=> !s_reg.flags[pim_pkg::SRC_REM_FAULT])
		else $error("status read left remote fault set");

	// an expansion read releases page received
	page_expan_a: assert property ( // [R14]
		!s_reg.alt_irq_select && rd_expan && !src_rise[pim_pkg::SRC_PAGE_RX]
		|=> !s_reg.flags[pim_pkg::SRC_PAGE_RX])
		else $error("expansion read left page flag set");

	// falling energy releases its flag
	energy_fall_a: assert property ( // [R8]
		!s_reg.alt_irq_select && src_fall[pim_pkg::SRC_ENERGY]
		|=> !s_reg.flags[pim_pkg::SRC_ENERGY])
		else $error("energy fall did not release its flag");

	// falling negotiation complete releases its flag
	an_fall_a: assert property ( // [R9]
		!s_reg.alt_irq_select && src_fall[pim_pkg::SRC_AN_DONE]
		|=> !s_reg.flags[pim_pkg::SRC_AN_DONE])
		else $error("negotiation fall did not release its flag");

	// falling acknowledge releases its flag
	ack_fall_a: assert property ( // [R12]
		!s_reg.alt_irq_select && src_fall[pim_pkg::SRC_LP_ACK]
		|=> !s_reg.flags[pim_pkg::SRC_LP_ACK])
		else $error("acknowledge fall did not release its flag");

	// link loss releases detection fault as well
	link_loss_a: assert property ( // [R13]
		!s_reg.alt_irq_select && src_rise[pim_pkg::SRC_LINK_DOWN]
		&& !src_rise[pim_pkg::SRC_PD_FAULT] |=> !s_reg.flags[pim_pkg::SRC_PD_FAULT])
		else $error("link loss did not release detection fault");

	// the late pulse drives the pin while energy stays enabled
	late_low_a: assert property ( // [R18]
		late_pulse && s_reg.mask[pim_pkg::SRC_ENERGY] && !wr_mask |=> !IRQ_N_OUT)
		else $error("late energy pulse not on the output");

	// in the alternate scheme only a checked write drops a flag
	alt_hold_a: assert property ( // [R16]
		s_reg.alt_irq_select && !wr_flags
		|=> (s_reg.flags & $past(s_reg.flags)) == $past(s_reg.flags))
		else $error("alternate mode dropped a flag without a write");

	// a flag read answers with the flags before its own clear
	read_value_a: assert property ( // [R21]
		rd_flags |=> REG_RVALID_OUT && REG_RDATA_OUT[7:1] == $past(s_reg.flags))
		else $error("flag read returned a wrong value");

	// a mask write stores the enables as written
	mask_write_a: assert property ( // [R5]
		wr_mask |=> s_reg.mask == $past(REG_REQ_IN.wdata[7:1]))
		else $error("mask write not stored");

	cov_irq: cover property ($fell(IRQ_N_OUT));
	cov_alt_clear: cover property (s_reg.alt_irq_select && wr_flags ##1 $rose(IRQ_N_OUT));
	cov_read_clear: cover property (rd_flags && !IRQ_N_OUT ##1 IRQ_N_OUT);
	cov_late_irq: cover property ($rose(late_pulse) ##1 !IRQ_N_OUT);
endmodule

/* pim_host_model.sv */
// host side model: management master and interrupt input of the host
`timescale 1ns/1ps
module pim_host_model (
	// clock
	input  wire logic                   clk_in,
	// management requests toward the device
	output pim_pkg::pim_reg_req_s       req_out,
	input  wire logic [15:0]            rdata_in,
	input  wire logic                   rvalid_in,
	// interrupt line as the host sees it
	input  wire logic                   irq_n_in
);
	// ============================================================
	// request state
	// idle request from time zero so no strobe is seen during reset
	initial begin
		req_out = '{addr: 5'h00, rd: 1'h0, wr: 1'h0, wdata: 16'h0000};
	end

	// one write cycle; strobe lowered on the edge that takes it
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_in);
		req_out <= '{addr: a, rd: 1'h0, wr: 1'h1, wdata: d};
		@(posedge clk_in);
		req_out.wr <= 1'h0;
	endtask

	// one read cycle; waits a bounded time for the answer
	// addresses without an answer return all ones
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		int n;
		@(posedge clk_in);
		req_out <= '{addr: a, rd: 1'h1, wr: 1'h0, wdata: 16'h0000};
		@(posedge clk_in);
		req_out.rd <= 1'h0;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (rvalid_in !== 1'h1 && n < 3);
		d = (rvalid_in === 1'h1) ? rdata_in : 16'hFFFF;
	endtask

	// alternate scheme is not kept over reset, so the host sets it again
	task automatic alt_setup;
		wr(pim_pkg::REG_MODE_CTRL, 16'h0040);
	endtask
endmodule

/* test_pim_irq_manager.sv */
// self-checking testbench of the phy interrupt manager
`timescale 1ns/1ps
module test_pim_irq_manager;
	// ============================================================
	// signals
	localparam int DLY = 20;          // shortened late-pulse wait
	localparam int PLS = 10;          // shortened late-pulse length
	logic                  clk;       // 20 MHz bench clock
	logic                  rst;       // synchronous reset
	pim_pkg::pim_status_s  st;        // source levels
	logic                  an_rst;    // negotiation restart pulse
	pim_pkg::pim_reg_req_s req;       // management request
	logic [15:0]           rdata;     // read data
	logic                  rvalid;    // read answer strobe
	logic                  irq_n;     // interrupt, active low
	logic                  alt;       // alternate scheme selected
	int                    error_cnt;
	int                    samples_checked;
	int                    cycles;    // timeout counter
	int                    n;         // low-cycle counter

	// ============================================================
	// device and host
	pim_irq_manager #(.ENERGY_DELAY_CYC(DLY), .ENERGY_PULSE_CYC(PLS)) uut (
		.MCLK_IN(clk), .RST_IN(rst), .STATUS_IN(st), .AN_RESTART_IN(an_rst),
		.REG_REQ_IN(req), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
		.IRQ_N_OUT(irq_n), .ALT_IRQ_SELECT_OUT(alt));
	pim_host_model host (.clk_in(clk), .req_out(req), .rdata_in(rdata),
		.rvalid_in(rvalid), .irq_n_in(irq_n));

	// ============================================================
	// clock and watchdog
	always #25 clk = ~clk;

	// a hang ends the run as a failure; the sequence needs about 390 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			error_cnt++;
			results();
		end
	end

	// ============================================================
	// helpers
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results;
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// wait three edges so the registered pin, one flip-flop behind the sources, has settled before looking at it
	task automatic irq(input logic exp);
		repeat (3) @(posedge clk);
		check("irq_n", {15'h0000, irq_n}, {15'h0000, exp});
	endtask

	task automatic rdchk(input logic [4:0] a, input logic [15:0] exp, input string nm);
		logic [15:0] d;
		host.rd(a, d);
		check(nm, d, exp);
	endtask

	// drive a source active (1) or idle (0); link status is inverted
	task automatic src(input int b, input logic v);
		@(posedge clk);
		st[b-1] <= (b == 4) ? !v : v;
	endtask

	task automatic hit(input int b);
		src(b, 1'h1);
		irq(1'h0);
	endtask

	// ============================================================
	// main sequence
	initial begin
		logic [15:0] d;
		clk = 1'h0;
		rst = 1'h1;
		st = 7'h48;    // energy present at acquisition start, link up
		an_rst = 1'h0;
		error_cnt = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		// reset state: all masked, so a set flag leaves the pin high
		irq(1'h1);
		check("alt_rst", {15'h0000, alt}, 16'h0000);
		rdchk(pim_pkg::REG_IRQ_FLAGS, 16'h0080, "flags_pwr");
		rdchk(pim_pkg::REG_IRQ_MASK, 16'h0000, "mask_rst");
		host.wr(pim_pkg::REG_IRQ_MASK, 16'hFFFF);
		rdchk(pim_pkg::REG_IRQ_MASK, 16'h00FE, "mask_rw");
		// every source: edge sets its own flag, a flag read releases it
		for (int b = 1; b <= 7; b++) begin
			src(b, 1'h0);
			hit(b);
			rdchk(pim_pkg::REG_IRQ_FLAGS, 16'(32'h1 << b), "flag_src");
			irq(1'h1);
			if (b != 7) begin
				src(b, 1'h0);
			end
		end
		// energy flag was read away with energy present: late pulse on removal
		src(7, 1'h0);
		n = 0;
		repeat (18) begin
			@(posedge clk);
			n += (irq_n === 1'h0) ? 1 : 0;
		end
		check("late_wait", 16'(n), 16'h0000);
		n = 0;
		repeat (42) begin
			@(posedge clk);
			n += (irq_n === 1'h0) ? 1 : 0;
		end
		check("late_len", 16'(n), 16'(PLS));
		// handler masks energy before removal: no late pulse
		hit(7);
		rdchk(pim_pkg::REG_IRQ_FLAGS, 16'h0080, "flag_hdl");
		host.wr(pim_pkg::REG_IRQ_MASK, 16'h007E);
		src(7, 1'h0);
		n = 0;
		repeat (40) begin
			@(posedge clk);
			n += (irq_n === 1'h0) ? 1 : 0;
		end
		check("late_masked", 16'(n), 16'h0000);
		// falling source releases without any read
		for (int b = 1; b <= 6; b++) begin
			if (b == 4) begin
				continue;
			end
			hit(b);
			src(b, 1'h0);
			irq(1'h1);
		end
		// basic status read releases remote fault and link down
		hit(5);
		host.rd(pim_pkg::REG_BASIC_STATUS, d);
		irq(1'h1);
		src(5, 1'h0);
		hit(4);
		src(4, 1'h0);
		irq(1'h0);
		host.rd(pim_pkg::REG_BASIC_STATUS, d);
		irq(1'h1);
		// expansion read and negotiation restart release fault and page
		for (int b = 1; b <= 2; b++) begin
			hit(b);
			host.rd(pim_pkg::REG_AN_EXPANSION, d);
			irq(1'h1);
			src(b, 1'h0);
			hit(b);
			@(posedge clk);
			an_rst <= 1'h1;
			@(posedge clk);
			an_rst <= 1'h0;
			irq(1'h1);
			src(b, 1'h0);
		end
		// alternate scheme: write-one check against the source level
		host.alt_setup();
		@(posedge clk);
		check("alt_set", {15'h0000, alt}, 16'h0001);
		hit(5);
		host.wr(pim_pkg::REG_IRQ_FLAGS, 16'h0020);
		irq(1'h0);
		rdchk(pim_pkg::REG_IRQ_FLAGS, 16'h0020, "alt_keep");
		src(5, 1'h0);
		irq(1'h0);
		host.wr(pim_pkg::REG_IRQ_FLAGS, 16'h0020);
		irq(1'h1);
		rdchk(pim_pkg::REG_IRQ_FLAGS, 16'h0000, "alt_clr");
		hit(4);
		host.wr(pim_pkg::REG_IRQ_FLAGS, 16'h0010);
		irq(1'h0);
		src(4, 1'h0);
		host.wr(pim_pkg::REG_IRQ_FLAGS, 16'h0010);
		irq(1'h1);
		// clearing the mask releases the pin at once
		hit(6);
		host.wr(pim_pkg::REG_IRQ_MASK, 16'h0000);
		irq(1'h1);
		src(6, 1'h0);
		// second reset returns to the primary scheme
		@(posedge clk);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		irq(1'h1);
		check("alt_rst2", {15'h0000, alt}, 16'h0000);
		rdchk(pim_pkg::REG_IRQ_FLAGS, 16'h0000, "flags_rst2");
		results();
	end
endmodule
